// ---- core/crt_regs.v ----
// Result presentation, auto-trigger edge logic and input disable registers on classic Wishbone
//
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "crt_defines.vh"

module crt_regs (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output wire wb_ack_o,
	output wire wb_err_o,
	input wire conv_done_i,
	input wire [9:0] conversion_result_i,
	input wire flag_comparator_i,
	input wire flag_ext_int0_i,
	input wire flag_t0_cmp_a_i,
	input wire flag_t0_ovf_i,
	input wire flag_t1_cmp_b_i,
	input wire flag_t1_ovf_i,
	input wire flag_t1_capture_i,
	input wire [5:0] port_pin_raw_i,
	output reg [5:0] port_pin_o,
	output reg [5:0] pin_buffer_off_o,
	output reg conv_start_o,
	output reg converter_enable_o,
	output reg [3:0] channel_select_bits_o,
	output reg comparator_mux_enable_o
);

	// Trigger flag multiplexer, code 0 returns the done flag (free running)
	function sel_flag;
		input [2:0] code;
		input [7:0] flags;
		begin
			sel_flag = flags[code];
		end
	endfunction

	reg [7:0] ctrl_a_q;
	reg [7:0] in_sel_q;
	reg [7:0] ctrl_b_q;
	reg [5:0] pin_input_disable_bits_q;
	reg [9:0] result_q;
	reg lock_q;
	reg trig_prev_q;
	reg [2:0] ts_prev_q;
	reg ack_q;
	reg busy_q;
	reg [5:0] pin_s1_q;
	reg [5:0] pin_s2_q;
	reg [7:0] src_s1_q;
	reg [7:0] src_s2_q;

	wire [7:0] raw_flags;
	wire [7:0] flags;
	wire left_adjust_select;
	wire [2:0] trigger_source_select;
	wire trig_now;
	wire trig_edge;
	wire req;
	wire wr;
	wire rd;
	wire hit;
	wire [7:0] wbyte;
	wire [7:0] wbyte_a;
	wire [7:0] result_low_byte;
	wire [7:0] result_high_byte;
	wire done_set;
	wire done_clr;
	wire start_req;

	// Strobes are single-cycle: ack follows one cycle after a request
	assign req = wb_cyc_i & wb_stb_i & ~ack_q;
	assign hit = (wb_adr_i <= `CRT_IDX_DIS);
	assign wr = req & wb_we_i & wb_sel_i[0] & hit;
	assign rd = req & ~wb_we_i & hit;
	assign wbyte = wb_dat_i[7:0];
	assign wbyte_a = wbyte & `CRT_A_WMASK;
	assign wb_ack_o = ack_q & hit;
	assign wb_err_o = ack_q & ~hit;

	assign left_adjust_select = in_sel_q[`CRT_SEL_LEFT];
	assign trigger_source_select = ctrl_b_q[2:0];

	// Result bytes formed combinationally so alignment changes apply at once
	assign result_high_byte = left_adjust_select ? result_q[9:2] : {6'h0, result_q[9:8]}; // RULE_01 RULE_02 RULE_18
	assign result_low_byte = left_adjust_select ? {result_q[1:0], 6'h0} : result_q[7:0]; // RULE_01 RULE_02 RULE_18

	// Trigger flags pass two flops since they come from other logic blocks' pins
	assign raw_flags = {flag_t1_capture_i, flag_t1_ovf_i, flag_t1_cmp_b_i, flag_t0_ovf_i,
		flag_t0_cmp_a_i, flag_ext_int0_i, flag_comparator_i, 1'b0};
	assign flags = {src_s2_q[7:1], ctrl_a_q[`CRT_A_DONE]}; // RULE_08

	assign trig_now = sel_flag(trigger_source_select, flags); // RULE_08
	// Edge against previous sample; switching into free running is never an edge
	assign trig_edge = trig_now & ~trig_prev_q & // RULE_21 RULE_09 RULE_10
		~((trigger_source_select == `CRT_TS_FREE) && (ts_prev_q != `CRT_TS_FREE)); // RULE_11

	// Done flag: hardware set wins over software clear
	assign done_set = conv_done_i & ~lock_q; // RULE_19 RULE_04
	assign done_clr = wr & (wb_adr_i == `CRT_IDX_CTRL_A) & wbyte[`CRT_A_DONE]; // RULE_19

	assign start_req = wr & (wb_adr_i == `CRT_IDX_CTRL_A) & wbyte[`CRT_A_START] & wbyte[`CRT_A_ENABLE];

	// Synchronisers for trigger flags and port pins
	always @(posedge clk_i) begin
		if (rst_i) begin
			src_s1_q <= `CRT_RST_BYTE;
			src_s2_q <= `CRT_RST_BYTE;
			pin_s1_q <= 6'h0;
			pin_s2_q <= 6'h0;
		end else begin
			src_s1_q <= raw_flags;
			src_s2_q <= src_s1_q;
			pin_s1_q <= port_pin_raw_i;
			pin_s2_q <= pin_s1_q;
		end
	end

	// Register file, result capture and trigger logic
	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_a_q <= `CRT_RST_BYTE;
			in_sel_q <= `CRT_RST_BYTE;
			ctrl_b_q <= `CRT_RST_BYTE; // RULE_06
			pin_input_disable_bits_q <= 6'h0; // RULE_06
			result_q <= 10'h000; // RULE_06
			lock_q <= 1'b0;
			trig_prev_q <= 1'b0;
			ts_prev_q <= `CRT_TS_FREE;
			ack_q <= 1'b0;
			busy_q <= 1'b0;
			conv_start_o <= 1'b0;
		end else begin
			ack_q <= req;
			trig_prev_q <= trig_now; // RULE_21
			ts_prev_q <= trigger_source_select;
			// Writes
			if (wr && wb_adr_i == `CRT_IDX_CTRL_A) begin
				ctrl_a_q[7:5] <= wbyte_a[7:5];
				ctrl_a_q[3:0] <= wbyte[3:0];
			end
			if (wr && wb_adr_i == `CRT_IDX_IN_SEL)
				in_sel_q <= wbyte & `CRT_SEL_WMASK;
			if (wr && wb_adr_i == `CRT_IDX_CTRL_B)
				ctrl_b_q <= wbyte & `CRT_B_WMASK; // RULE_12
			if (wr && wb_adr_i == `CRT_IDX_DIS)
				pin_input_disable_bits_q <= wbyte[5:0]; // RULE_17 RULE_16
			// Done flag, set beats clear
			if (done_set)
				ctrl_a_q[`CRT_A_DONE] <= 1'b1; // RULE_19
			else if (done_clr)
				ctrl_a_q[`CRT_A_DONE] <= 1'b0; // RULE_19
			// Result capture, held off while the low byte has been read
			if (done_set)
				result_q <= conversion_result_i; // RULE_03 RULE_04
			if (rd && wb_adr_i == `CRT_IDX_RES_LOW)
				lock_q <= 1'b1; // RULE_04
			else if (rd && wb_adr_i == `CRT_IDX_RES_HIGH)
				lock_q <= 1'b0; // RULE_04
			// Conversion start pulse from software or auto trigger
			conv_start_o <= ctrl_a_q[`CRT_A_ENABLE] & (start_req |
				(ctrl_a_q[`CRT_A_AUTO] & trig_edge)); // RULE_07 RULE_09 RULE_20 RULE_10
			if (~ctrl_a_q[`CRT_A_ENABLE] || conv_done_i)
				busy_q <= 1'b0;
			else if (conv_start_o)
				busy_q <= 1'b1;
		end
	end

	// Read mux and pin gating
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
			port_pin_o <= 6'h0;
			pin_buffer_off_o <= 6'h0;
			converter_enable_o <= 1'b0;
			channel_select_bits_o <= 4'h0;
			comparator_mux_enable_o <= 1'b0;
		end else begin
			port_pin_o <= pin_s2_q & ~pin_input_disable_bits_q; // RULE_14
			pin_buffer_off_o <= pin_input_disable_bits_q; // RULE_13
			converter_enable_o <= ctrl_a_q[`CRT_A_ENABLE];
			channel_select_bits_o <= in_sel_q[3:0];
			comparator_mux_enable_o <= ctrl_b_q[`CRT_B_CMP_MUX];
			wb_dat_o <= 32'h0000_0000;
			if (rd) begin
				case (wb_adr_i)
					`CRT_IDX_RES_LOW: wb_dat_o[7:0] <= result_low_byte;
					`CRT_IDX_RES_HIGH: wb_dat_o[7:0] <= result_high_byte;
					`CRT_IDX_CTRL_A: wb_dat_o[7:0] <= {ctrl_a_q[7], busy_q | conv_start_o, ctrl_a_q[5:0]};
					`CRT_IDX_CTRL_B: wb_dat_o[7:0] <= ctrl_b_q;
					`CRT_IDX_IN_SEL: wb_dat_o[7:0] <= in_sel_q;
					`CRT_IDX_DIS: wb_dat_o[7:0] <= {2'b00, pin_input_disable_bits_q};
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule // crt_regs

// ---- shared/crt_defines.vh ----
// Register offsets, field positions, reset values and decode constants for the converter register block
//
// Operation
// RULE_01: Right alignment: result 9:8 in high byte 1:0, 7:0 in low byte.
// RULE_02: Left alignment: result 9:2 in high byte, 1:0 in low byte 7:6.
// RULE_03: Completed conversion result appears in the two result byte registers.
// RULE_04: Low byte read blocks result updates until the high byte is read.
// RULE_05: Software reads low byte before high byte; high alone suffices left-aligned.
// RULE_06: Result bytes, control B and input disable reset to zero.
// RULE_07: Trigger source field acts only while auto triggering is enabled.
// RULE_08: Source codes: free run, comparator, ext int0, t0 cmpA, t0 ovf, t1 cmpB, t1 ovf, t1 capture.
// RULE_09: Auto triggering starts a conversion on each rising edge of selected flag.
// RULE_10: Switching from a clear source to a set source counts as rising edge.
// RULE_11: Switching to free running never produces a trigger event.
// RULE_12: Software writes zeros to reserved control B bits 7 and 5:3.
// RULE_13: Each of six disable bits turns off its pin's digital input buffer.
// RULE_14: A set disable bit forces the port pin input bit to read zero.
// RULE_15: Software should disable digital inputs on analog pins to save power.
// RULE_16: Channels 6 and 7 have no input buffer and no disable bit.
// RULE_17: Software writes zeros to reserved input disable bits 7 and 6.
// RULE_18: Left-adjust change alters result presentation immediately.
// RULE_19: Done flag sets when result registers update; writing one clears it.
// RULE_20: Auto-trigger enable in control A gates trigger edges.
// RULE_21: Edges found by comparing selected flag with previous clock's sample.
`ifndef CRT_DEFINES_VH
`define CRT_DEFINES_VH

// Word addresses on the bus (byte address = index * 4)
`define CRT_IDX_RES_LOW 4'h0
`define CRT_IDX_RES_HIGH 4'h1
`define CRT_IDX_CTRL_A 4'h2
`define CRT_IDX_CTRL_B 4'h3
`define CRT_IDX_IN_SEL 4'h4
`define CRT_IDX_DIS 4'h5

// Control A fields
`define CRT_A_ENABLE 7
`define CRT_A_START 6
`define CRT_A_AUTO 5
`define CRT_A_DONE 4
`define CRT_A_WMASK 8'h_E0
// Input select fields
`define CRT_SEL_LEFT 5
`define CRT_SEL_WMASK 8'h_EF
// Control B fields
`define CRT_B_CMP_MUX 6
`define CRT_B_WMASK 8'h_47
// Input disable writable bits
`define CRT_DIS_WMASK 8'h_3F

`define CRT_RST_BYTE 8'h_00

// Trigger source codes
`define CRT_TS_FREE 3'h0
`define CRT_TS_COMP 3'h1
`define CRT_TS_EXT0 3'h2
`define CRT_TS_T0CA 3'h3
`define CRT_TS_T0OV 3'h4
`define CRT_TS_T1CB 3'h5
`define CRT_TS_T1OV 3'h6
`define CRT_TS_T1CP 3'h7

`endif

// ---- bench/crt_regs_monitor.sv ----
// Bus and output checks for the converter register block
`timescale 1ns/1ps
module crt_regs_monitor (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire [3:0] wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire wb_err_o,
	input wire [5:0] port_pin_o,
	input wire [5:0] pin_buffer_off_o,
	input wire conv_start_o,
	input wire converter_enable_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// New request seen while no answer is up
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	// Bus answer timing and read data shape
	ack_timing_a: assert property (req && wb_adr_i <= 4'h5 |=> wb_ack_o)
		else $error("ack late");
	err_unmapped_a: assert property (req && wb_adr_i > 4'h5 |=> wb_err_o && !wb_ack_o)
		else $error("err missing");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	ack_cause_a: assert property (wb_ack_o |-> $past(req))
		else $error("ack without request");
	dat_quiet_a: assert property (!wb_ack_o && !wb_err_o |-> wb_dat_o == 32'h0)
		else $error("read data not cleared");
	// Pin gating and start pulse
	pin_gate_a: assert property ((port_pin_o & pin_buffer_off_o & $past(pin_buffer_off_o)) == 6'h0)
		else $error("disabled pin reads one");
	start_single_a: assert property (conv_start_o |=> !conv_start_o)
		else $error("start pulse too long");
	start_enable_a: assert property (conv_start_o |-> converter_enable_o)
		else $error("start while disabled");
	cover property (conv_start_o);
	cover property (wb_err_o);
	cover property (wb_ack_o && wb_dat_o != 32'h0);
endmodule // crt_regs_monitor

bind crt_regs crt_regs_monitor mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
	.wb_err_o, .port_pin_o, .pin_buffer_off_o, .conv_start_o, .converter_enable_o);

// ---- bench/crt_regs_bench.sv ----
// Self-checking bench for the converter register block
`timescale 1ns/1ps
module crt_regs_bench;
	reg clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, conv_done_i = 0, qe;
	reg [3:0] wb_adr_i = 0;
	reg [31:0] wb_dat_i = 0, q;
	reg [9:0] conversion_result_i = 0;
	reg [6:0] flg = 0;
	reg [5:0] port_pin_raw_i = 6'h3F;
	wire [31:0] wb_dat_o;
	wire wb_ack_o, wb_err_o, conv_start_o;
	wire [5:0] port_pin_o, pin_buffer_off_o;
	integer error_cnt = 0, num_checks = 0, starts = 0, cnt = 0, n0, i;
	crt_regs uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .wb_err_o, .conv_done_i, .conversion_result_i, .flag_comparator_i(flg[0]),
		.flag_ext_int0_i(flg[1]), .flag_t0_cmp_a_i(flg[2]), .flag_t0_ovf_i(flg[3]), .flag_t1_cmp_b_i(flg[4]),
		.flag_t1_ovf_i(flg[5]), .flag_t1_capture_i(flg[6]), .port_pin_raw_i, .port_pin_o, .pin_buffer_off_o,
		.conv_start_o, .converter_enable_o(), .channel_select_bits_o(), .comparator_mux_enable_o());
	always #10 clk_i = ~clk_i;
	// Count start pulses and cut a hang short
	always @(posedge clk_i) begin
		starts <= starts + conv_start_o;
		cnt <= cnt + 1;
		if (cnt == 3000) begin
			error_cnt = error_cnt + 1;
			end_of_test;
		end
	end
	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", num_checks, error_cnt);
			if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
			else $display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				error_cnt = error_cnt + 1;
				$display("Error %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	// One classic cycle; answer taken at the rising edge that sees ack or err, then released
	task bus(input [3:0] a, input w, input [7:0] d);
		begin
			@(posedge clk_i);
			wb_cyc_i <= 1;
			wb_stb_i <= 1;
			wb_we_i <= w;
			wb_adr_i <= a;
			wb_dat_i <= {24'h0, d};
			@(posedge clk_i);
			while (!(wb_ack_o || wb_err_o)) @(posedge clk_i);
			q = wb_dat_o;
			qe = wb_err_o;
			wb_cyc_i <= 0;
			wb_stb_i <= 0;
		end
	endtask
	task rd(input [3:0] a, input [7:0] e);
		begin
			bus(a, 0, 0);
			chk("read data", {24'h0, e}, q);
		end
	endtask
	task conv(input [9:0] r);
		begin
			@(posedge clk_i);
			conv_done_i <= 1;
			conversion_result_i <= r;
			@(posedge clk_i);
			conv_done_i <= 0;
		end
	endtask
	// Select a source, pulse its flag and count the starts
	task trig(input [2:0] c, input integer e);
		begin
			bus(3, 1, {5'h0, c});
			n0 = starts;
			@(posedge clk_i);
			flg[c - 1] <= 1;
			repeat (8) @(posedge clk_i);
			flg[c - 1] <= 0;
			repeat (8) @(posedge clk_i);
			chk("starts", e, starts - n0);
		end
	endtask
	// Main sequence
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		for (i = 0; i < 6; i = i + 1) if (i != 2 && i != 4) rd(i, 0);
		bus(4'h6, 0, 0);
		chk("err", 1, qe);
		$display("reset test done");
		conv(10'h2A5);
		rd(0, 8'hA5);
		rd(1, 8'h02);
		bus(4, 1, 8'h20);
		rd(0, 8'h40);
		conv(10'h15A);
		rd(1, 8'hA9);
		rd(0, 8'h40);
		rd(1, 8'hA9);
		conv(10'h15A);
		rd(0, 8'h80);
		rd(1, 8'h56);
		bus(4, 1, 8'h00);
		rd(0, 8'h5A);
		rd(1, 8'h01);
		$display("result test done");
		chk("pins", 6'h3F, port_pin_o);
		bus(3, 1, 8'h47);
		rd(3, 8'h47);
		bus(5, 1, 8'h3F);
		rd(5, 8'h3F);
		repeat (4) @(posedge clk_i);
		chk("pins", 0, port_pin_o);
		chk("buffer off", 6'h3F, pin_buffer_off_o);
		bus(5, 1, 8'h15);
		repeat (4) @(posedge clk_i);
		chk("pins", 6'h2A, port_pin_o);
		$display("pin test done");
		bus(2, 1, 8'h80);
		trig(1, 0);
		bus(2, 1, 8'hA0);
		for (i = 1; i < 8; i = i + 1) trig(i, 1);
		@(posedge clk_i);
		flg[1] <= 1;
		repeat (8) @(posedge clk_i);
		n0 = starts;
		bus(3, 1, 8'h02);
		repeat (8) @(posedge clk_i);
		chk("starts", 1, starts - n0);
		flg[1] <= 0;
		bus(3, 1, 8'h01);
		conv(10'h0);
		n0 = starts;
		bus(3, 1, 8'h00);
		repeat (8) @(posedge clk_i);
		chk("starts", 0, starts - n0);
		bus(2, 1, 8'hB0);
		rd(2, 8'hA0);
		n0 = starts;
		conv(10'h3FF);
		repeat (8) @(posedge clk_i);
		chk("starts", 1, starts - n0);
		$display("trigger test done");
		end_of_test;
	end
endmodule // crt_regs_bench
